// file: common/fcw_regs.vh
/*
 Constants of the flash configuration write command interpreter: report
 codes, byte positions, status values, pin settings fields and the APB map.
 Assumes one includer per compile unit; the guard covers the rest.
*/
// Operation
// - Report code B1 in byte 0, byte 1 selects which stored item is written.
// - Output-mode general pin three drives stored bit 4 after reset; bits 7-5 ignored.
// - Stored bit 3 sets pin direction, 1 input, 0 output, general-purpose mode only.
// - Low three bits pick pin function; codes 100 to 111 are ignored.
// - Sub-command 02 stores the manufacturer string descriptor.
// - Sub-command 03 stores the product string descriptor.
// - Sub-command 04 stores the serial number string descriptor.
// - Characters are 16 bits, low byte at 4 plus twice n, high next.
// - Character index runs 0 to 30, at most thirty-one characters.
// - Answer echoes B1 and status 00 success, 02 unsupported, 03 not allowed.
// - Protected configuration needs a matching password before any update.
// - Password command does nothing when unprotected or permanently locked.
// - Sub-command 01 stores the power-up settings of the general pins.
// - Password report: code B2, byte 1 ignored, password in bytes 2 to 9.
// - After the allowed failed attempts every password gets status 03.
`ifndef FCW_REGS_VH
`define FCW_REGS_VH

// ==========================================================
// Report codes and byte positions
`define FCW_CODE_WRITE 8'hB1
`define FCW_CODE_PASSWORD 8'hB2
`define FCW_SUB_PINS 8'h01
`define FCW_SUB_MFR 8'h02
`define FCW_SUB_PROD 8'h03
`define FCW_SUB_SERIAL 8'h04
`define FCW_IDX_CODE 7'h00
`define FCW_IDX_SUB 7'h01
`define FCW_IDX_LEN 7'h02
`define FCW_IDX_STR0 7'h04
`define FCW_IDX_PIN3 7'h05
`define FCW_IDX_PW0 7'h02
`define FCW_IDX_PW_LAST 7'h09
`define FCW_IDX_LAST 7'h41
`define FCW_CHAR_MAX 6'h1E
`define FCW_LEN_OVERHEAD 8'h02

// ==========================================================
// Status values
`define FCW_ST_OK 8'h00
`define FCW_ST_UNSUP 8'h02
`define FCW_ST_DENIED 8'h03

// ==========================================================
// Pin settings byte fields and function codes
`define FCW_PIN_VALUE 4
`define FCW_PIN_DIR 3
`define FCW_PIN_FUNC 2:0
`define FCW_PIN_KEEP 4:0
`define FCW_FUNC_GPIO 3'h0
`define FCW_FUNC_ACT 3'h1
`define FCW_FUNC_AIN 3'h2
`define FCW_FUNC_AOUT 3'h3
`define FCW_FUNC_RSVD 2

// ==========================================================
// APB register byte offsets
`define FCW_REG_CTRL 8'h00
`define FCW_REG_CMD_INDEX 8'h04
`define FCW_REG_CMD_DATA 8'h08
`define FCW_REG_RESPONSE 8'h0C
`define FCW_REG_PIN_SETTINGS 8'h10
`define FCW_REG_PROTECT 8'h14
`define FCW_REG_PASSWORD_LO 8'h18
`define FCW_REG_PASSWORD_HI 8'h1C
`define FCW_REG_STRING_ADDR 8'h20
`define FCW_REG_STRING_DATA 8'h24
`define FCW_REG_STRING_LEN 8'h28

// Control bits
`define FCW_CTRL_EXEC 0
`define FCW_CTRL_APPLY 1
`define FCW_PROT_ON 0
`define FCW_PROT_LOCK 1

`endif

// file: hdl/fcw_string_mem.v
/*
 Descriptor string storage: one write port, one read port whose data come
 out of a register one clock after the address.
 Assumes the writer never addresses beyond the depth.
*/
`timescale 1ns/1ns
module fcw_string_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 128,
  parameter AW = 7
) (
  input wire clock,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] cells [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end

endmodule // fcw_string_mem

// file: hdl/fcw_top.v
/*
 Flash configuration write command interpreter with an APB slave.
 Software pushes a report byte by byte, then executes it; the answer and
 the stored configuration are readable. Drives general pin three.
 Assumes an APB master on clock and a pin input from outside the domain.
*/
`timescale 1ns/1ns
`include "fcw_regs.vh"
module fcw_top #(
  parameter AW = 8,
  parameter [7:0] PIN_DEFAULT = 8'h08,
  parameter FAIL_W = 4,
  parameter [FAIL_W-1:0] MAX_FAILS = 4'h3
) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire general_pin_three_in,
  output reg general_pin_three_out,
  output reg general_pin_three_oe,
  output reg serial_activity_indicator_en,
  output reg analog_input_channel_three_en,
  output reg analog_output_channel_two_en
);

  // ==========================================================
  // Report collection states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_COLLECT = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [1:0] state;
  reg [6:0] idx;
  reg [7:0] cmd_code;
  reg [7:0] cmd_sub;
  reg [7:0] cmd_len;
  reg [7:0] pin_pending;
  reg pin_seen;
  reg pw_match;
  reg [7:0] low_hold;
  reg [7:0] resp_code;
  reg [7:0] resp_status;
  reg resp_valid;
  reg [7:0] pin_cfg;
  reg prot_on;
  reg prot_lock;
  reg unlocked;
  reg [FAIL_W-1:0] fails;
  reg [63:0] password;
  reg [1:0] str_sel;
  reg [4:0] str_char;
  reg [4:0] len_mfr;
  reg [4:0] len_prod;
  reg [4:0] len_serial;
  reg pin_sync1;
  reg pin_sync2;
  wire [15:0] str_rd_data;

  // ==========================================================
  // Decoding shared by the collector and the commit
  function allow_update;
    input on;
    input lock;
    input unl;
    input [FAIL_W-1:0] nfail;
    input [FAIL_W-1:0] limit;
    begin
      allow_update = !lock && (!on || unl) && (nfail < limit);
    end
  endfunction

  function is_string_sub;
    input [7:0] sub;
    begin
      is_string_sub = (sub == `FCW_SUB_MFR) || (sub == `FCW_SUB_PROD) || (sub == `FCW_SUB_SERIAL);
    end
  endfunction

  // Character count from the length byte, clamped to the storable range
  function [4:0] char_count;
    input [7:0] len;
    reg [7:0] body;
    begin
      body = (len > `FCW_LEN_OVERHEAD) ? (len - `FCW_LEN_OVERHEAD) : 8'h00;
      char_count = (body[7:1] > {1'b0, `FCW_CHAR_MAX}) ? 5'h1F : body[5:1];
    end
  endfunction

  // ==========================================================
  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_done = psel && penable && pready;
  wire wr_hit = apb_done && pwrite;
  wire wr_ctrl = wr_hit && (paddr == `FCW_REG_CTRL);
  wire wr_index = wr_hit && (paddr == `FCW_REG_CMD_INDEX);
  wire wr_byte = wr_hit && (paddr == `FCW_REG_CMD_DATA);
  wire exec = wr_ctrl && pwdata[`FCW_CTRL_EXEC] && (state == ST_COLLECT);
  wire apply = wr_ctrl && pwdata[`FCW_CTRL_APPLY];
  wire [7:0] in_byte = pwdata[7:0];
  wire may_update = allow_update(prot_on, prot_lock, unlocked, fails, MAX_FAILS);

  wire mapped = (paddr == `FCW_REG_CTRL) || (paddr == `FCW_REG_CMD_INDEX) ||
    (paddr == `FCW_REG_CMD_DATA) || (paddr == `FCW_REG_RESPONSE) ||
    (paddr == `FCW_REG_PIN_SETTINGS) || (paddr == `FCW_REG_PROTECT) ||
    (paddr == `FCW_REG_PASSWORD_LO) || (paddr == `FCW_REG_PASSWORD_HI) ||
    (paddr == `FCW_REG_STRING_ADDR) || (paddr == `FCW_REG_STRING_DATA) ||
    (paddr == `FCW_REG_STRING_LEN);

  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `FCW_REG_CMD_INDEX: next_prdata = {25'h0000000, idx};
      `FCW_REG_RESPONSE: next_prdata = {15'h0000, resp_valid, resp_status, resp_code};
      `FCW_REG_PIN_SETTINGS: next_prdata = {23'h000000, pin_sync2, pin_cfg};
      `FCW_REG_PROTECT: next_prdata = {{(24-FAIL_W){1'b0}}, fails, 5'h00, unlocked, prot_lock, prot_on};
      `FCW_REG_PASSWORD_LO: next_prdata = may_update ? password[31:0] : 32'h0000_0000;
      `FCW_REG_PASSWORD_HI: next_prdata = may_update ? password[63:32] : 32'h0000_0000;
      `FCW_REG_STRING_ADDR: next_prdata = {19'h00000, str_char, 6'h00, str_sel};
      `FCW_REG_STRING_DATA: next_prdata = {16'h0000, str_rd_data};
      `FCW_REG_STRING_LEN: next_prdata = {11'h000, len_serial, 3'h0, len_prod, 3'h0, len_mfr};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // One access cycle per transfer: pready rises for the first access cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end else if (apb_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Pin input synchroniser
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= general_pin_three_in;
      pin_sync2 <= pin_sync1;
    end
  end

  // ==========================================================
  // String writes go straight to storage as the high byte arrives
  wire [6:0] char_ofs = idx - `FCW_IDX_STR0;
  wire [5:0] char_num = char_ofs[6:1];
  wire [7:0] sub_ofs = cmd_sub - `FCW_SUB_MFR;
  wire str_ok = (state == ST_COLLECT) && (cmd_code == `FCW_CODE_WRITE) && is_string_sub(cmd_sub) &&
    (resp_status == `FCW_ST_OK);
  wire str_byte = wr_byte && str_ok && (idx >= `FCW_IDX_STR0) && (char_num <= `FCW_CHAR_MAX);
  wire str_wr = str_byte && char_ofs[0];
  wire [6:0] str_wr_addr = {sub_ofs[1:0], char_num[4:0]};

  fcw_string_mem #(
    .WIDTH(16),
    .DEPTH(128),
    .AW(7)
  ) u_strings (
    .clock(clock),
    .wr_en(str_wr),
    .wr_addr(str_wr_addr),
    .wr_data({in_byte, low_hold}),
    .rd_addr({str_sel, str_char}),
    .rd_data(str_rd_data)
  );

  // ==========================================================
  // Report collector and commit
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      idx <= 7'h00;
      cmd_code <= 8'h00;
      cmd_sub <= 8'h00;
      cmd_len <= 8'h00;
      pin_pending <= 8'h00;
      pin_seen <= 1'b0;
      pw_match <= 1'b0;
      low_hold <= 8'h00;
      resp_code <= 8'h00;
      resp_status <= `FCW_ST_UNSUP;
      resp_valid <= 1'b0;
      pin_cfg <= PIN_DEFAULT;
      len_mfr <= 5'h00;
      len_prod <= 5'h00;
      len_serial <= 5'h00;
      unlocked <= 1'b0;
      fails <= {FAIL_W{1'b0}};
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (wr_index) begin
            state <= ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          if (exec) begin
            state <= ST_DONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (wr_index) begin
        idx <= pwdata[6:0];
        resp_valid <= 1'b0;
        resp_status <= `FCW_ST_UNSUP;
        pin_seen <= 1'b0;
        pw_match <= 1'b1;
        cmd_len <= 8'h00;
      end else if (wr_byte && state == ST_COLLECT) begin
        if (idx < `FCW_IDX_LAST) begin
          idx <= idx + 7'h01;
        end
        if (idx == `FCW_IDX_CODE) begin
          cmd_code <= in_byte;
        end
        if (idx == `FCW_IDX_SUB) begin
          cmd_sub <= in_byte;
          if (cmd_code == `FCW_CODE_WRITE) begin
            if (in_byte < `FCW_SUB_PINS || in_byte > `FCW_SUB_SERIAL) begin
              resp_status <= `FCW_ST_UNSUP;
            end else begin
              resp_status <= may_update ? `FCW_ST_OK : `FCW_ST_DENIED;
            end
          end else if (cmd_code == `FCW_CODE_PASSWORD) begin
            resp_status <= `FCW_ST_OK;
          end
        end
        if (idx == `FCW_IDX_LEN) begin
          cmd_len <= in_byte;
        end
        if (idx == `FCW_IDX_PIN3) begin
          pin_pending <= in_byte;
          pin_seen <= 1'b1;
        end
        if (idx >= `FCW_IDX_PW0 && idx <= `FCW_IDX_PW_LAST) begin
          if (in_byte != password[{idx[2:0] - 3'h2, 3'h0} +: 8]) begin
            pw_match <= 1'b0;
          end
        end
        if (str_byte && !char_ofs[0]) begin
          low_hold <= in_byte;
        end
      end
      if (exec) begin
        resp_valid <= 1'b1;
        resp_code <= cmd_code;
        if (cmd_code == `FCW_CODE_WRITE && resp_status == `FCW_ST_OK) begin
          case (cmd_sub)
            `FCW_SUB_PINS: begin
              // Reserved function codes keep the stored function
              if (pin_seen && pin_pending[`FCW_FUNC_RSVD]) begin
                pin_cfg <= {3'b000, pin_pending[`FCW_PIN_VALUE], pin_pending[`FCW_PIN_DIR],
                  pin_cfg[`FCW_PIN_FUNC]};
              end else if (pin_seen) begin
                pin_cfg <= {3'b000, pin_pending[`FCW_PIN_KEEP]};
              end
            end
            `FCW_SUB_MFR: len_mfr <= char_count(cmd_len);
            `FCW_SUB_PROD: len_prod <= char_count(cmd_len);
            `FCW_SUB_SERIAL: len_serial <= char_count(cmd_len);
            default: len_mfr <= len_mfr;
          endcase
        end else if (cmd_code == `FCW_CODE_PASSWORD) begin
          if (!prot_on || prot_lock) begin
            resp_status <= `FCW_ST_OK;
          end else if (fails >= MAX_FAILS) begin
            resp_status <= `FCW_ST_DENIED;
          end else if (pw_match) begin
            unlocked <= 1'b1;
            resp_status <= `FCW_ST_OK;
          end else begin
            fails <= fails + {{(FAIL_W-1){1'b0}}, 1'b1};
            unlocked <= 1'b0;
            resp_status <= `FCW_ST_DENIED;
          end
        end else if (cmd_code != `FCW_CODE_WRITE) begin
          resp_status <= `FCW_ST_UNSUP;
        end
      end
      if (wr_hit && paddr == `FCW_REG_PROTECT && may_update) begin
        unlocked <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Protection setup and stored password; lock is one-way until reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prot_on <= 1'b0;
      prot_lock <= 1'b0;
      password <= 64'h0000_0000_0000_0000;
      str_sel <= 2'b00;
      str_char <= 5'h00;
    end else begin
      if (wr_hit && paddr == `FCW_REG_PROTECT && may_update) begin
        prot_on <= pwdata[`FCW_PROT_ON];
        prot_lock <= pwdata[`FCW_PROT_LOCK];
      end
      if (wr_hit && paddr == `FCW_REG_PASSWORD_LO && may_update) begin
        password[31:0] <= pwdata;
      end
      if (wr_hit && paddr == `FCW_REG_PASSWORD_HI && may_update) begin
        password[63:32] <= pwdata;
      end
      if (wr_hit && paddr == `FCW_REG_STRING_ADDR) begin
        str_sel <= pwdata[1:0];
        str_char <= pwdata[12:8];
      end
    end
  end

  // ==========================================================
  // Pin drive: taken from stored settings at reset and on apply only,
  // so a fresh settings write behaves like a power-up value
  wire [2:0] func = pin_cfg[`FCW_PIN_FUNC];
  localparam [2:0] DFLT_FUNC = PIN_DEFAULT[`FCW_PIN_FUNC];
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      general_pin_three_out <= PIN_DEFAULT[`FCW_PIN_VALUE];
      general_pin_three_oe <= (DFLT_FUNC == `FCW_FUNC_GPIO) && !PIN_DEFAULT[`FCW_PIN_DIR];
      serial_activity_indicator_en <= (DFLT_FUNC == `FCW_FUNC_ACT);
      analog_input_channel_three_en <= (DFLT_FUNC == `FCW_FUNC_AIN);
      analog_output_channel_two_en <= (DFLT_FUNC == `FCW_FUNC_AOUT);
    end else if (apply) begin
      general_pin_three_out <= pin_cfg[`FCW_PIN_VALUE];
      general_pin_three_oe <= (func == `FCW_FUNC_GPIO) && !pin_cfg[`FCW_PIN_DIR];
      serial_activity_indicator_en <= (func == `FCW_FUNC_ACT);
      analog_input_channel_three_en <= (func == `FCW_FUNC_AIN);
      analog_output_channel_two_en <= (func == `FCW_FUNC_AOUT);
    end
  end

endmodule // fcw_top

// file: tb/fcw_monitor.sv
/*
 Checker for fcw_top: APB timing and pin output relations.
 Assumes it is bound to fcw_top and sees only its ports.
*/
`timescale 1ns/1ns
module fcw_monitor #(
  parameter AW = 8
) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire general_pin_three_out,
  input wire general_pin_three_oe,
  input wire serial_activity_indicator_en,
  input wire analog_input_channel_three_en,
  input wire analog_output_channel_two_en
);
  wire acc = psel && penable && pready;
  wire [2:0] fn = {serial_activity_indicator_en, analog_input_channel_three_en, analog_output_channel_two_en};
  wire [4:0] pins = {general_pin_three_oe, general_pin_three_out, fn};
  reg apply_d1;
  reg apply_d2;
  // ==========================================================
  // Apply history: pins may only move shortly after an apply write
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      apply_d1 <= 1'b0;
      apply_d2 <= 1'b0;
    end else begin
      apply_d1 <= acc && pwrite && paddr == 8'h00 && pwdata[1];
      apply_d2 <= apply_d1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  AST_UNMAPPED: assert property (acc && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not flagged");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read returned data");
  AST_FUNC_EXCL: assert property ($onehot0(fn))
    else $error("two pin functions enabled");
  AST_OE_GPIO: assert property (general_pin_three_oe |-> fn == 3'h0)
    else $error("pin driven outside gpio mode");
  AST_PIN_CAUSE: assert property ($changed(pins) |-> apply_d1 || apply_d2)
    else $error("pin outputs moved without apply");
endmodule // fcw_monitor
bind fcw_top fcw_monitor #(.AW(AW)) fcw_monitor_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .general_pin_three_out(general_pin_three_out), .general_pin_three_oe(general_pin_three_oe),
  .serial_activity_indicator_en(serial_activity_indicator_en),
  .analog_input_channel_three_en(analog_input_channel_three_en),
  .analog_output_channel_two_en(analog_output_channel_two_en));

// file: tb/fcw_host_model.sv
/*
 Host side model: issues APB transfers carrying report bytes.
 Assumes a zero or more wait state APB slave on the same clock.
*/
`timescale 1ns/1ns
module fcw_host_model (
  input wire clock,
  input wire pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Request held until pready seen at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Plain loop instead of an event guard, which some free simulators refuse
    do
      @(posedge clock);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // fcw_host_model

// file: tb/flash_config_write_commands_bench.sv
/*
 Self-checking bench for fcw_top: reports, pins, strings, password.
 Assumes fcw_host_model drives APB and fcw_monitor is bound.
*/
`timescale 1ns/1ns
`include "fcw_regs.vh"
module flash_config_write_commands_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pin_in = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic p_out, p_oe, en_act, en_ain, en_aout;
  logic [32:0] expq[$];
  logic [7:0] rpt[0:65];
  logic [15:0] chars[0:2][0:30];
  logic [31:0] lfsr = 32'h1580;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  fcw_host_model fcw_host_model_i (.clock(clock), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  fcw_top fcw_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_pin_three_in(pin_in), .general_pin_three_out(p_out), .general_pin_three_oe(p_oe),
    .serial_activity_indicator_en(en_act), .analog_input_channel_three_en(en_ain),
    .analog_output_channel_two_en(en_aout));
  // ==========================================================
  // Checking and closing
  task check(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, expq.pop_front());
    if (cycles > 40000) begin
      miscompares++;
      summarize();
    end
  end
  function logic [7:0] rnd;
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    return lfsr[7:0];
  endfunction
  // ==========================================================
  // Bus and report helpers
  task wr(input logic [7:0] a, input logic [31:0] d);
    fcw_host_model_i.xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    fcw_host_model_i.xfer(1'b0, a, 32'h0);
  endtask
  // Sends bytes 0..n-1 of rpt, executes, reads answer
  task send(input int n, input logic [7:0] st);
    wr(`FCW_REG_CMD_INDEX, 32'h0);
    for (int i = 0; i < n; i++)
      wr(`FCW_REG_CMD_DATA, {24'h0, rpt[i]});
    wr(`FCW_REG_CTRL, 32'h1);
    rd(`FCW_REG_RESPONSE, {17'h1, st, rpt[0]});
  endtask
  task pin_rpt(input logic [7:0] b5, input logic [7:0] st);
    for (int i = 0; i < 6; i++)
      rpt[i] = rnd();
    rpt[0] = `FCW_CODE_WRITE;
    rpt[1] = `FCW_SUB_PINS;
    rpt[5] = b5;
    send(6, st);
  endtask
  task pw_rpt(input logic [31:0] lo, input logic [31:0] hi, input logic [7:0] st);
    rpt[0] = `FCW_CODE_PASSWORD;
    rpt[1] = rnd();
    for (int i = 0; i < 4; i++) begin
      rpt[2 + i] = lo[8 * i +: 8];
      rpt[6 + i] = hi[8 * i +: 8];
    end
    send(10, st);
  endtask
  task reset_dut;
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask
  // ==========================================================
  // Pin table: byte 5, stored byte, {oe, oe and out, act, ain, aout}
  logic [7:0] pb[0:6] = '{8'hF0, 8'h09, 8'h02, 8'h1B, 8'h0C, 8'h00, 8'h08};
  logic [7:0] ps[0:6] = '{8'h10, 8'h09, 8'h02, 8'h1B, 8'h0B, 8'h00, 8'h08};
  logic [4:0] po[0:6] = '{5'h18, 5'h04, 5'h02, 5'h01, 5'h01, 5'h10, 5'h00};
  initial begin
    reset_dut();
    check({28'h0, p_oe, p_oe & p_out, en_act, en_ain, en_aout}, 33'h0);
    // Pin input needs two edges through its synchroniser
    repeat (2) @(posedge clock);
    rd(`FCW_REG_PIN_SETTINGS, {1'b0, 32'h108});
    rd(8'h30, {1'b1, 32'h0});
    for (int k = 0; k < 7; k++) begin
      pin_rpt(pb[k], `FCW_ST_OK);
      rd(`FCW_REG_PIN_SETTINGS, {1'b0, 24'h1, ps[k]});
      wr(`FCW_REG_CTRL, 32'h2);
      repeat (3) @(posedge clock);
      check({28'h0, p_oe, p_oe & p_out, en_act, en_ain, en_aout}, {28'h0, po[k]});
    end
    // Strings of 31, 2 and 1 characters
    for (int s = 0; s < 3; s++) begin
      automatic int n = (s == 0) ? 31 : 3 - s;
      rpt[0] = `FCW_CODE_WRITE;
      rpt[1] = `FCW_SUB_MFR + s;
      rpt[2] = 8'(2 + 2 * n);
      rpt[3] = 8'h03;
      for (int c = 0; c < n; c++) begin
        chars[s][c] = {rnd(), rnd()};
        rpt[4 + 2 * c] = chars[s][c][7:0];
        rpt[5 + 2 * c] = chars[s][c][15:8];
      end
      send(4 + 2 * n, `FCW_ST_OK);
    end
    rd(`FCW_REG_STRING_LEN, {1'b0, 32'h0001_021F});
    wr(`FCW_REG_STRING_ADDR, 32'h1E00);
    rd(`FCW_REG_STRING_DATA, {17'h0, chars[0][30]});
    wr(`FCW_REG_STRING_ADDR, 32'h0001);
    rd(`FCW_REG_STRING_DATA, {17'h0, chars[1][0]});
    wr(`FCW_REG_STRING_ADDR, 32'h0002);
    rd(`FCW_REG_STRING_DATA, {17'h0, chars[2][0]});
    // Unsupported sub-command and unknown code
    rpt[0] = `FCW_CODE_WRITE;
    rpt[1] = 8'h05;
    send(2, `FCW_ST_UNSUP);
    rpt[0] = 8'h55;
    send(2, `FCW_ST_UNSUP);
    // Protection, password and failure limit
    wr(`FCW_REG_PASSWORD_LO, 32'h4433_2211);
    wr(`FCW_REG_PASSWORD_HI, 32'h8877_6655);
    wr(`FCW_REG_PROTECT, 32'h1);
    pin_rpt(8'h10, `FCW_ST_DENIED);
    pw_rpt(32'h4433_2211, 32'h0877_6655, `FCW_ST_DENIED);
    pw_rpt(32'h4433_2211, 32'h8877_6655, `FCW_ST_OK);
    pin_rpt(8'h10, `FCW_ST_OK);
    pw_rpt(32'h0, 32'h0, `FCW_ST_DENIED);
    pw_rpt(32'h1, 32'h0, `FCW_ST_DENIED);
    pw_rpt(32'h4433_2211, 32'h8877_6655, `FCW_ST_DENIED);
    pin_rpt(8'h08, `FCW_ST_DENIED);
    rd(`FCW_REG_PROTECT, {1'b0, 32'h0000_0301});
    // Unprotected and locked: password has no effect
    reset_dut();
    pw_rpt(32'h5, 32'h6, `FCW_ST_OK);
    pin_rpt(8'h00, `FCW_ST_OK);
    wr(`FCW_REG_PROTECT, 32'h2);
    pw_rpt(32'h5, 32'h6, `FCW_ST_OK);
    pin_rpt(8'h00, `FCW_ST_DENIED);
    rd(`FCW_REG_PROTECT, {1'b0, 32'h0000_0002});
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule // flash_config_write_commands_bench
